/* wssm_top.sv */
// Function
// - The set current of winding B reads back as a signed mA value clamped to -15000..15000, zero after reset.
// - Winding A sense offset is a writable signed mA value in -500..500, zero after reset.
// - Winding B sense offset is a writable signed mA value in -500..500, zero after reset.
// - Winding A current-to-voltage ratio is writable in 2000..6000 and resets to 4724.
// - Winding B current-to-voltage ratio is writable in 2000..6000 and resets to 4770.
// - The voltage group entry count always reads 7.
// - The measured supply voltage reads in 0.01 V steps, 0..6000, zero after reset.
// - A supply below the lower warning limit (default 4100) raises a warning.
// - A supply above the upper warning limit (default 5500) raises a warning.
// - A supply below the lower error limit (default 3800) raises an error.
// - A supply above the upper error limit (default 5800) raises an error.
`timescale 1ns/10ps
`default_nettype none
module wssm_top
  import wssm_pkg::*;
#(
  parameter int unsigned SAMPLE_W = 16
)
(
  // clock and reset
  input  wire logic                 REF_CLK,
  input  wire logic                 RST_N,
  // register bus, write
  input  wire logic [ADDR_W-1:0]    AWADDR,
  input  wire logic                 AWVALID,
  output var  logic                 AWREADY,
  input  wire logic [DATA_W-1:0]    WDATA,
  input  wire logic [3:0]           WSTRB,
  input  wire logic                 WVALID,
  output var  logic                 WREADY,
  output var  logic [1:0]           BRESP,
  output var  logic                 BVALID,
  input  wire logic                 BREADY,
  // register bus, read
  input  wire logic [ADDR_W-1:0]    ARADDR,
  input  wire logic                 ARVALID,
  output var  logic                 ARREADY,
  output var  logic [DATA_W-1:0]    RDATA,
  output var  logic [1:0]           RRESP,
  output var  logic                 RVALID,
  input  wire logic                 RREADY,
  // measurements
  input  wire logic [15:0]          SET_CURRENT_B,
  input  wire logic [SAMPLE_W-1:0]  SUPPLY_SAMPLE,
  input  wire logic                 SUPPLY_VALID,
  // calibration to current sensing
  output var  logic [15:0]          OFFSET_A,
  output var  logic [15:0]          OFFSET_B,
  output var  logic [15:0]          RATIO_A,
  output var  logic [15:0]          RATIO_B,
  // status
  output var  logic                 SUPPLY_WARNING,
  output var  logic                 SUPPLY_ERROR,
  output var  logic                 IRQ
);

  // full scale 6000 needs 13 bits; wider than the datapath is not served
  if (SAMPLE_W < 13 || SAMPLE_W > VAL_W)
  begin : g_bad_width
    $error("SAMPLE_W must lie between 13 and 16");
  end

  wssm_thr_if tif ();

  wssm_cmp u_cmp (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .tif   (tif)
  );

  logic [ADDR_W-1:0]  wr_addr;
  logic [15:0]        wr_data;
  logic [3:0]         wr_strb;
  logic               aw_full;
  logic               w_full;
  logic               do_write;
  logic [15:0]        cur16;
  logic [15:0]        merged;
  logic               wr_known;
  logic               wr_ok;
  logic [1:0]         wr_resp;
  logic [15:0]        set_cur_b;
  logic [NUM_EV-1:0]  cond_q;
  logic [NUM_EV-1:0]  irq_stat;
  logic [NUM_EV-1:0]  irq_en;
  logic [NUM_EV-1:0]  irq_clr;
  logic [DATA_W-1:0]  rd_data;
  logic [1:0]         rd_resp;

  assign tif.sample_valid = SUPPLY_VALID;
  assign tif.sample       = VAL_W'(SUPPLY_SAMPLE);

  // write address and data are taken in either order
  assign do_write = aw_full && w_full && !BVALID;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      aw_full <= 1'b0;
      AWREADY <= 1'b0;
      wr_addr <= '0;
    end
    else if (AWVALID && AWREADY)
    begin
      aw_full <= 1'b1;
      AWREADY <= 1'b0;
      wr_addr <= AWADDR;
    end
    else if (do_write)
      aw_full <= 1'b0;
    else
      AWREADY <= !aw_full;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      w_full  <= 1'b0;
      WREADY  <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end
    else if (WVALID && WREADY)
    begin
      w_full  <= 1'b1;
      WREADY  <= 1'b0;
      wr_data <= WDATA[15:0];
      wr_strb <= WSTRB;
    end
    else if (do_write)
      w_full <= 1'b0;
    else
      WREADY <= !w_full;
  end

  // byte lanes merge into the present value before the range test
  always_comb
  begin
    unique case (wr_addr)
      OFF_OFFS_A:    cur16 = OFFSET_A;
      OFF_OFFS_B:    cur16 = OFFSET_B;
      OFF_RATIO_A:   cur16 = RATIO_A;
      OFF_RATIO_B:   cur16 = RATIO_B;
      OFF_LOW_WARN:  cur16 = tif.low_warn;
      OFF_HIGH_WARN: cur16 = tif.high_warn;
      OFF_LOW_ERR:   cur16 = tif.low_err;
      OFF_HIGH_ERR:  cur16 = tif.high_err;
      default:       cur16 = RST_ZERO;
    endcase
    merged[7:0]  = wr_strb[0] ? wr_data[7:0]  : cur16[7:0];
    merged[15:8] = wr_strb[1] ? wr_data[15:8] : cur16[15:8];
  end

  always_comb
  begin
    wr_known = 1'b1;
    unique case (wr_addr)
      OFF_OFFS_A, OFF_OFFS_B:
        wr_ok = $signed(merged) >= OFFS_MIN && $signed(merged) <= OFFS_MAX;
      OFF_RATIO_A, OFF_RATIO_B:
        wr_ok = $signed(merged) >= RATIO_MIN
                && $signed(merged) <= RATIO_MAX;
      OFF_LOW_WARN, OFF_HIGH_WARN, OFF_LOW_ERR, OFF_HIGH_ERR:
        wr_ok = merged <= VOLT_MAX;
      OFF_IRQ_EN, OFF_IRQ_CLR:
        wr_ok = 1'b1;
      OFF_SET_CUR_B, OFF_GRP_COUNT, OFF_SUPPLY, OFF_STATUS,
      OFF_WARN_BITS, OFF_ERR_BITS, OFF_IRQ_STAT:
        wr_ok = 1'b0;
      default:
      begin
        wr_ok    = 1'b0;
        wr_known = 1'b0;
      end
    endcase
    if (!wr_known)
      wr_resp = RESP_DECERR;
    else if (!wr_ok)
      wr_resp = RESP_SLVERR;
    else
      wr_resp = RESP_OKAY;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      BVALID <= 1'b0;
      BRESP  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      BVALID <= 1'b1;
      BRESP  <= wr_resp;
    end
    else if (BREADY)
      BVALID <= 1'b0;
  end

  // offsets, refused when out of range
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      OFFSET_A <= RST_ZERO;
      OFFSET_B <= RST_ZERO;
    end
    else if (do_write && wr_ok)
    begin
      if (wr_addr == OFF_OFFS_A)
        OFFSET_A <= merged;
      if (wr_addr == OFF_OFFS_B)
        OFFSET_B <= merged;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      RATIO_A <= RST_RATIO_A;
      RATIO_B <= RST_RATIO_B;
    end
    else if (do_write && wr_ok)
    begin
      if (wr_addr == OFF_RATIO_A)
        RATIO_A <= merged;
      if (wr_addr == OFF_RATIO_B)
        RATIO_B <= merged;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      tif.low_warn  <= RST_LOW_WARN;
      tif.high_warn <= RST_HIGH_WARN;
      tif.low_err   <= RST_LOW_ERR;
      tif.high_err  <= RST_HIGH_ERR;
    end
    else if (do_write && wr_ok)
    begin
      if (wr_addr == OFF_LOW_WARN)
        tif.low_warn <= merged;
      if (wr_addr == OFF_HIGH_WARN)
        tif.high_warn <= merged;
      if (wr_addr == OFF_LOW_ERR)
        tif.low_err <= merged;
      if (wr_addr == OFF_HIGH_ERR)
        tif.high_err <= merged;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      set_cur_b <= RST_ZERO;
    else if ($signed(SET_CURRENT_B) < CUR_MIN)
      set_cur_b <= CUR_MIN;
    else if ($signed(SET_CURRENT_B) > CUR_MAX)
      set_cur_b <= CUR_MAX;
    else
      set_cur_b <= SET_CURRENT_B;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      SUPPLY_WARNING <= 1'b0;
      SUPPLY_ERROR   <= 1'b0;
      cond_q         <= '0;
    end
    else
    begin
      SUPPLY_WARNING <= tif.cond[EV_LOW_WARN] || tif.cond[EV_HIGH_WARN];
      SUPPLY_ERROR   <= tif.cond[EV_LOW_ERR] || tif.cond[EV_HIGH_ERR];
      cond_q         <= tif.cond;
    end
  end

  assign irq_clr = (do_write && wr_addr == OFF_IRQ_CLR && wr_strb[0])
                   ? wr_data[NUM_EV-1:0] : '0;

  // sticky onset bits; a new onset beats a clear in the same cycle
  for (genvar i = 0; i < NUM_EV; i++)
  begin : g_ev
    always_ff @(posedge REF_CLK)
    begin
      if (!RST_N)
        irq_stat[i] <= 1'b0;
      else if (tif.cond[i] && !cond_q[i])
        irq_stat[i] <= 1'b1;
      else if (irq_clr[i])
        irq_stat[i] <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      irq_en <= '0;
    else if (do_write && wr_addr == OFF_IRQ_EN && wr_strb[0])
      irq_en <= wr_data[NUM_EV-1:0];
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      IRQ <= 1'b0;
    else
      IRQ <= |(irq_stat & irq_en);
  end

  // read mux, unused upper bits read zero
  always_comb
  begin
    rd_data = '0;
    rd_resp = RESP_OKAY;
    unique case (ARADDR)
      OFF_SET_CUR_B: rd_data[15:0] = set_cur_b;
      OFF_OFFS_A:    rd_data[15:0] = OFFSET_A;
      OFF_OFFS_B:    rd_data[15:0] = OFFSET_B;
      OFF_RATIO_A:   rd_data[15:0] = RATIO_A;
      OFF_RATIO_B:   rd_data[15:0] = RATIO_B;
      OFF_GRP_COUNT: rd_data[7:0]  = GROUP_COUNT;
      OFF_SUPPLY:    rd_data[15:0] = tif.voltage;
      OFF_LOW_WARN:  rd_data[15:0] = tif.low_warn;
      OFF_HIGH_WARN: rd_data[15:0] = tif.high_warn;
      OFF_LOW_ERR:   rd_data[15:0] = tif.low_err;
      OFF_HIGH_ERR:  rd_data[15:0] = tif.high_err;
      OFF_STATUS:
      begin
        rd_data[ST_WARN_BIT] = SUPPLY_WARNING;
        rd_data[ST_ERR_BIT]  = SUPPLY_ERROR;
      end
      OFF_WARN_BITS: rd_data[1:0] = tif.cond[EV_HIGH_WARN:EV_LOW_WARN];
      OFF_ERR_BITS:  rd_data[1:0] = tif.cond[EV_HIGH_ERR:EV_LOW_ERR];
      OFF_IRQ_STAT:  rd_data[NUM_EV-1:0] = irq_stat;
      OFF_IRQ_EN:    rd_data[NUM_EV-1:0] = irq_en;
      OFF_IRQ_CLR:   rd_data = '0;
      default:       rd_resp = RESP_DECERR;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= '0;
      RRESP   <= RESP_OKAY;
    end
    else if (ARVALID && ARREADY)
    begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RDATA   <= rd_data;
      RRESP   <= rd_resp;
    end
    else if (RVALID && RREADY)
    begin
      RVALID  <= 1'b0;
      ARREADY <= 1'b1;
    end
    else if (!RVALID)
      ARREADY <= 1'b1;
  end

  AST_SET_CUR_B:
  assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $signed(set_cur_b) >= CUR_MIN && $signed(set_cur_b) <= CUR_MAX)
    else $error("set current of winding B out of range");

  AST_OFFS_A:
  assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $signed(OFFSET_A) >= OFFS_MIN && $signed(OFFSET_A) <= OFFS_MAX)
    else $error("winding A offset out of range");

  AST_OFFS_B:
  assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $signed(OFFSET_B) >= OFFS_MIN && $signed(OFFSET_B) <= OFFS_MAX)
    else $error("winding B offset out of range");

  AST_RATIO_A:
  assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $signed(RATIO_A) >= RATIO_MIN && $signed(RATIO_A) <= RATIO_MAX)
    else $error("winding A ratio out of range");

  AST_RATIO_B:
  assert property (@(posedge REF_CLK) disable iff (!RST_N)
    do_write && wr_ok && wr_addr == OFF_RATIO_B
    |=> RATIO_B == $past(merged) && $signed(RATIO_B) >= RATIO_MIN)
    else $error("winding B ratio write not taken");

  AST_GRP_COUNT:
  assert property (@(posedge REF_CLK) disable iff (!RST_N)
    ARVALID && ARREADY && ARADDR == OFF_GRP_COUNT
    |=> RVALID && RDATA == 32'h0000_0007 && RRESP == RESP_OKAY)
    else $error("entry count did not read 7");

  AST_SUPPLY:
  assert property (@(posedge REF_CLK) disable iff (!RST_N)
    SUPPLY_VALID && tif.sample <= VOLT_MAX
    |=> tif.voltage == $past(tif.sample))
    else $error("supply reading not captured");

  AST_LOW_WARN:
  assert property (@(posedge REF_CLK) disable iff (!RST_N)
    SUPPLY_VALID && tif.sample < tif.low_warn
    |=> tif.cond[EV_LOW_WARN] ##1 SUPPLY_WARNING)
    else $error("low supply warning missing");

  AST_HIGH_WARN:
  assert property (@(posedge REF_CLK) disable iff (!RST_N)
    SUPPLY_VALID && tif.sample > tif.high_warn
    |=> tif.cond[EV_HIGH_WARN] ##1 SUPPLY_WARNING)
    else $error("high supply warning missing");

  AST_LOW_ERR:
  assert property (@(posedge REF_CLK) disable iff (!RST_N)
    SUPPLY_VALID && tif.sample < tif.low_err
    |=> tif.cond[EV_LOW_ERR] ##1 SUPPLY_ERROR)
    else $error("low supply error missing");

  AST_HIGH_ERR:
  assert property (@(posedge REF_CLK) disable iff (!RST_N)
    SUPPLY_VALID && tif.sample > tif.high_err && tif.sample <= VOLT_MAX
    |=> tif.cond[EV_HIGH_ERR] ##1 SUPPLY_ERROR)
    else $error("high supply error missing");

  AST_HOLD:
  assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !SUPPLY_VALID |=> $stable(tif.cond))
    else $error("supply flags moved without a sample");

  AST_REFUSE:
  assert property (@(posedge REF_CLK) disable iff (!RST_N)
    do_write && !wr_ok && wr_addr == OFF_OFFS_A
    |=> $stable(OFFSET_A) && BVALID && BRESP == RESP_SLVERR)
    else $error("out-of-range write was not refused");

endmodule
`default_nettype wire

/* wssm_pkg.sv */
package wssm_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned VAL_W  = 16;

  // register byte offsets
  localparam logic [7:0] OFF_SET_CUR_B  = 8'h00;
  localparam logic [7:0] OFF_OFFS_A     = 8'h04;
  localparam logic [7:0] OFF_OFFS_B     = 8'h08;
  localparam logic [7:0] OFF_RATIO_A    = 8'h0C;
  localparam logic [7:0] OFF_RATIO_B    = 8'h10;
  localparam logic [7:0] OFF_GRP_COUNT  = 8'h14;
  localparam logic [7:0] OFF_SUPPLY     = 8'h18;
  localparam logic [7:0] OFF_LOW_WARN   = 8'h1C;
  localparam logic [7:0] OFF_HIGH_WARN  = 8'h20;
  localparam logic [7:0] OFF_LOW_ERR    = 8'h24;
  localparam logic [7:0] OFF_HIGH_ERR   = 8'h28;
  localparam logic [7:0] OFF_STATUS     = 8'h2C;
  localparam logic [7:0] OFF_WARN_BITS  = 8'h30;
  localparam logic [7:0] OFF_ERR_BITS   = 8'h34;
  localparam logic [7:0] OFF_IRQ_STAT   = 8'h38;
  localparam logic [7:0] OFF_IRQ_EN     = 8'h3C;
  localparam logic [7:0] OFF_IRQ_CLR    = 8'h40;

  // reset values
  localparam logic [15:0] RST_ZERO      = 16'h0000;
  localparam logic [15:0] RST_RATIO_A   = 16'h1274;
  localparam logic [15:0] RST_RATIO_B   = 16'h12A2;
  localparam logic [7:0]  GROUP_COUNT   = 8'h07;
  localparam logic [15:0] RST_LOW_WARN  = 16'h1004;
  localparam logic [15:0] RST_HIGH_WARN = 16'h157C;
  localparam logic [15:0] RST_LOW_ERR   = 16'h0ED8;
  localparam logic [15:0] RST_HIGH_ERR  = 16'h16A8;

  // value ranges
  localparam logic signed [15:0] CUR_MIN   = 16'shC568;
  localparam logic signed [15:0] CUR_MAX   = 16'sh3A98;
  localparam logic signed [15:0] OFFS_MIN  = 16'shFE0C;
  localparam logic signed [15:0] OFFS_MAX  = 16'sh01F4;
  localparam logic signed [15:0] RATIO_MIN = 16'sh07D0;
  localparam logic signed [15:0] RATIO_MAX = 16'sh1770;
  localparam logic [15:0]        VOLT_MAX  = 16'h1770;

  // condition and status bit positions
  localparam int unsigned NUM_EV       = 4;
  localparam int unsigned EV_LOW_WARN  = 0;
  localparam int unsigned EV_HIGH_WARN = 1;
  localparam int unsigned EV_LOW_ERR   = 2;
  localparam int unsigned EV_HIGH_ERR  = 3;
  localparam int unsigned ST_WARN_BIT  = 0;
  localparam int unsigned ST_ERR_BIT   = 1;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

/* wssm_thr_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface wssm_thr_if;
  logic [15:0] low_warn;
  logic [15:0] high_warn;
  logic [15:0] low_err;
  logic [15:0] high_err;
  logic        sample_valid;
  logic [15:0] sample;
  logic [15:0] voltage;
  logic [3:0]  cond;

  modport bank (output low_warn, high_warn, low_err, high_err,
                output sample_valid, sample,
                input  voltage, cond);
  modport mon  (input  low_warn, high_warn, low_err, high_err,
                input  sample_valid, sample,
                output voltage, cond);
endinterface
`default_nettype wire

/* wssm_cmp.sv */
`timescale 1ns/10ps
`default_nettype none
module wssm_cmp
  import wssm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // thresholds, sample and conditions
  wssm_thr_if.mon  tif
);

  logic [15:0] sat;

  // out-of-range readings are pinned to full scale
  assign sat = (tif.sample > VOLT_MAX) ? VOLT_MAX : tif.sample;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tif.voltage <= RST_ZERO;
    else if (tif.sample_valid)
      tif.voltage <= sat;
  end

  // conditions only move on a new sample and hold until the next one
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tif.cond <= '0;
    else if (tif.sample_valid)
    begin
      tif.cond[EV_LOW_WARN]  <= sat < tif.low_warn;
      tif.cond[EV_HIGH_WARN] <= sat > tif.high_warn;
      tif.cond[EV_LOW_ERR]   <= sat < tif.low_err;
      tif.cond[EV_HIGH_ERR]  <= sat > tif.high_err;
    end
  end

endmodule
`default_nettype wire

/* wssm_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
// far side: supply sampler and set-point source
module wssm_far_model
(
  // clock
  input  wire logic        clk,
  // towards the bank
  output var  logic [15:0] sample,
  output var  logic        valid,
  output var  logic [15:0] set_cur
);
  initial
  begin
    sample  = 16'hFFFF;
    valid   = 1'b0;
    set_cur = 16'h0000;
  end

  task automatic send(input logic [15:0] v);
    @(posedge clk);
    sample <= v;
    valid  <= 1'b1;
    @(posedge clk);
    valid  <= 1'b0;
    // stale outside the pulse, so never a usable value
    sample <= ~v;
  endtask

  task automatic drive_cur(input logic [15:0] c);
    @(posedge clk);
    set_cur <= c;
  endtask
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import wssm_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, warn, err, irq;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [15:0] samp, cur, offs_a, offs_b, rat_a, rat_b, v;
  logic        samp_v;
  logic [15:0] lw = RST_LOW_WARN;
  logic [15:0] hw = RST_HIGH_WARN;
  logic [15:0] le = RST_LOW_ERR;
  logic [15:0] he = RST_HIGH_ERR;
  int          fails = 0;
  int          samples_checked = 0;
  logic [7:0]  ra [11] = '{OFF_SET_CUR_B, OFF_OFFS_A, OFF_OFFS_B,
    OFF_RATIO_A, OFF_RATIO_B, OFF_GRP_COUNT, OFF_SUPPLY, OFF_LOW_WARN,
    OFF_HIGH_WARN, OFF_LOW_ERR, OFF_HIGH_ERR};
  logic [15:0] rv [11] = '{RST_ZERO, RST_ZERO, RST_ZERO, RST_RATIO_A,
    RST_RATIO_B, 16'h0007, RST_ZERO, RST_LOW_WARN, RST_HIGH_WARN,
    RST_LOW_ERR, RST_HIGH_ERR};
  logic [7:0]  ca [4] = '{OFF_OFFS_A, OFF_OFFS_B, OFF_RATIO_A, OFF_RATIO_B};
  logic [15:0] cl [4] = '{OFFS_MIN, OFFS_MIN, RATIO_MIN, RATIO_MIN};
  logic [15:0] ch [4] = '{OFFS_MAX, OFFS_MAX, RATIO_MAX, RATIO_MAX};
  logic [15:0] sc [8] = '{16'd3799, 16'd3800, 16'd4099, 16'd4100,
    16'd5501, 16'd5800, 16'd5801, 16'd7000};
  logic [15:0] cc [4] = '{16'h3A98, 16'hC568, 16'h4E20, 16'hB1E0};

  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end

  wssm_far_model u_far (.clk(ref_clk), .sample(samp), .valid(samp_v),
    .set_cur(cur));

  wssm_top u_dut (.REF_CLK(ref_clk), .RST_N(rst_n), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .SET_CURRENT_B(cur), .SUPPLY_SAMPLE(samp),
    .SUPPLY_VALID(samp_v), .OFFSET_A(offs_a), .OFFSET_B(offs_b),
    .RATIO_A(rat_a), .RATIO_B(rat_b), .SUPPLY_WARNING(warn),
    .SUPPLY_ERROR(err), .IRQ(irq));

  task automatic close_out();
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    bit ad = 1'b0;
    bit wd = 1'b0;
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= {16'h0, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge ref_clk);
      if (awvalid && awready)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdt(input logic [7:0] a);
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    rdt(a);
    check($sformatf("reg %h", a), rd, {16'h0, e});
    check($sformatf("rresp %h", a), rs, RESP_OKAY);
  endtask

  task automatic wrc(input logic [7:0] a, input logic [15:0] d,
                     input logic [3:0] s, input logic [1:0] e);
    wr(a, d, s, rs);
    check($sformatf("bresp %h", a), rs, e);
  endtask

  function automatic logic [15:0] clampc(input logic signed [15:0] c);
    return (c > CUR_MAX) ? CUR_MAX : ((c < CUR_MIN) ? CUR_MIN : c);
  endfunction

  function automatic logic [15:0] port_of(input logic [7:0] a);
    case (a)
      OFF_OFFS_A: return offs_a;
      OFF_OFFS_B: return offs_b;
      OFF_RATIO_A: return rat_a;
      default: return rat_b;
    endcase
  endfunction

  task automatic supply(input logic [15:0] x);
    logic [15:0] s;
    logic [3:0]  c;
    s = (x > VOLT_MAX) ? VOLT_MAX : x;
    c = {s > he, s < le, s > hw, s < lw};
    u_far.send(x);
    repeat (4) @(posedge ref_clk);
    check("warning", warn, |c[1:0]);
    check("error", err, |c[3:2]);
    rdc(OFF_SUPPLY, s);
    rdc(OFF_STATUS, {14'h0, |c[3:2], |c[1:0]});
    rdc(OFF_WARN_BITS, {14'h0, c[1:0]});
    rdc(OFF_ERR_BITS, {14'h0, c[3:2]});
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    close_out();
  end

  initial
  begin
    void'($urandom(39039));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    check("ratio a out", rat_a, RST_RATIO_A);
    check("ratio b out", rat_b, RST_RATIO_B);
    foreach (ra[i])
      rdc(ra[i], rv[i]);
    for (int i = 0; i < 8; i++)
    begin
      v = (i < 4) ? cc[i] : 16'($urandom_range(30000) - 15000);
      u_far.drive_cur(v);
      repeat (2) @(posedge ref_clk);
      rdc(OFF_SET_CUR_B, clampc(v));
    end
    wrc(OFF_SET_CUR_B, 16'h0001, 4'h3, RESP_SLVERR);
    wrc(OFF_GRP_COUNT, 16'h0001, 4'h3, RESP_SLVERR);
    wrc(OFF_SUPPLY, 16'h0001, 4'h3, RESP_SLVERR);
    wrc(8'h80, 16'h0001, 4'h3, RESP_DECERR);
    rdt(8'h80);
    check("unmapped", {rs, rd}, {RESP_DECERR, 32'h0});
    for (int i = 0; i < 4; i++)
    begin
      wrc(ca[i], cl[i], 4'h3, RESP_OKAY);
      wrc(ca[i], ch[i] + 16'h1, 4'h3, RESP_SLVERR);
      wrc(ca[i], cl[i] - 16'h1, 4'h3, RESP_SLVERR);
      rdc(ca[i], cl[i]);
      wrc(ca[i], ch[i], 4'h3, RESP_OKAY);
      rdc(ca[i], ch[i]);
      v = cl[i] + 16'($urandom_range(ch[i] - cl[i]));
      wrc(ca[i], v, 4'h3, RESP_OKAY);
      check("cal out", port_of(ca[i]), v);
    end
    // low byte alone lifts 0x100 to 511, beyond the offset range
    wrc(OFF_OFFS_A, 16'h0100, 4'h3, RESP_OKAY);
    wrc(OFF_OFFS_A, 16'h00FF, 4'h1, RESP_SLVERR);
    rdc(OFF_OFFS_A, 16'h0100);
    foreach (sc[i])
      supply(sc[i]);
    for (int i = 0; i < 8; i++)
      supply(16'($urandom_range(7000)));
    supply(16'd5000);
    wrc(OFF_IRQ_CLR, 16'h000F, 4'h3, RESP_OKAY);
    wrc(OFF_IRQ_EN, 16'h0001, 4'h3, RESP_OKAY);
    check("irq idle", irq, 1'b0);
    supply(16'd4000);
    check("irq set", irq, 1'b1);
    rdc(OFF_IRQ_STAT, 16'h0001);
    wrc(OFF_IRQ_CLR, 16'h0001, 4'h3, RESP_OKAY);
    repeat (3) @(posedge ref_clk);
    check("irq clr", irq, 1'b0);
    rdc(OFF_IRQ_STAT, 16'h0000);
    supply(16'd3000);
    rdc(OFF_IRQ_STAT, 16'h0004);
    check("irq masked", irq, 1'b0);
    wrc(OFF_IRQ_EN, 16'h0004, 4'h3, RESP_OKAY);
    repeat (3) @(posedge ref_clk);
    check("irq en", irq, 1'b1);
    rdc(OFF_IRQ_CLR, 16'h0000);
    wrc(OFF_LOW_WARN, 16'd5000, 4'h3, RESP_OKAY);
    lw = 16'd5000;
    wrc(OFF_LOW_WARN, 16'd6001, 4'h3, RESP_SLVERR);
    rdc(OFF_LOW_WARN, 16'd5000);
    supply(16'd4900);
    wrc(OFF_HIGH_ERR, 16'd5700, 4'h3, RESP_OKAY);
    he = 16'd5700;
    supply(16'd5750);
    close_out();
  end
endmodule
`default_nettype wire
